// ---- hw/synth_core.sv ----
// Top of the synthesiser digital core: pin synchronisers, strobe storage register,
// reference divider, phase/frequency comparator, pump gain and monitor outputs.
// Assumes every input is an asynchronous pin and the RF input is no faster than a quarter
// of ref_clk_i, since RF edges are sampled rather than used as a clock.
`timescale 1ns/1ns
`include "synth_core_defs.svh"

module synth_core
(
	input  wire logic                      ref_clk_i,
	input  wire logic                      resetn_i,
	input  wire logic                      strobe_i,
	input  wire logic [`BUS_W-1:0]         prog_bus_i,
	input  wire logic [`REF_RATIO_W-1:0]   ref_ratio_i,
	input  wire logic                      rf_in_i,
	input  wire logic                      control_dir_i,
	input  wire logic                      monitor_en_i,
	output logic                           pump_up_o,
	output logic                           pump_down_o,
	output logic                           pump_output_en_o,
	output logic [`GAIN_W-1:0]             pump_gain_select_o,
	output logic [`GAIN_TENTHS_W-1:0]      pump_gain_tenths_o,
	output logic                           divided_rf_pulse_o,
	output logic                           divided_ref_pulse_o,
	output logic                           ratio_steppable_o
);

	// Pin vector layout for the shared synchroniser.
	localparam int PIN_W = `BUS_W + `REF_RATIO_W + 4;

	logic [1:0]                 rst_sync;
	logic                       rst_n;
	logic [PIN_W-1:0]           pin_raw;
	logic [PIN_W-1:0]           pin_s1;
	logic [PIN_W-1:0]           pin_s2;
	logic [PIN_W-1:0]           pin_s3;
	logic [PIN_W-1:0]           pin_f;
	logic                       strobe;
	logic [`BUS_W-1:0]          bus;
	logic [`REF_RATIO_W-1:0]    ref_ratio;
	logic                       rf_level;
	logic                       rf_level_d;
	logic                       dir;
	logic                       mon_en;
	logic                       rf_tick;
	synth_core_pkg::prog_word_s prog;
	logic [`REF_RATIO_W-1:0]    ref_cnt;
	logic                       ref_edge;
	logic                       rf_pulse;
	logic                       rf_edge;
	logic                       pfd_ref_edge;
	logic                       pfd_rf_edge;
	synth_core_pkg::pfd_state_e pfd_state;
	logic [`RATIO_W-1:0]        ratio;

	// Bitwise agreement filter: a bit moves only when the last two stages agree.
	function automatic logic [PIN_W-1:0] agree(input logic [PIN_W-1:0] s2,
		input logic [PIN_W-1:0] s3, input logic [PIN_W-1:0] held);
		agree = (s2 & s3) | (held & (s2 ^ s3));
	endfunction

	// Gain code to factor in tenths.
	function automatic logic [`GAIN_TENTHS_W-1:0] gain_tenths(input logic [`GAIN_W-1:0] code);
		unique case (code)
			`GAIN_X1_0: gain_tenths = `TENTHS_X1_0;
			`GAIN_X1_5: gain_tenths = `TENTHS_X1_5;
			`GAIN_X2_5: gain_tenths = `TENTHS_X2_5;
			`GAIN_X4_0: gain_tenths = `TENTHS_X4_0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.

	always_ff @(posedge ref_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage one feeds stage two only.

	assign pin_raw = {strobe_i, prog_bus_i, ref_ratio_i, rf_in_i, control_dir_i, monitor_en_i};

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f <= '0;
			rf_level_d <= 1'b0;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= agree(pin_s2, pin_s3, pin_f);
			rf_level_d <= rf_level;
		end
	end

	assign {strobe, bus, ref_ratio, rf_level, dir, mon_en} = pin_f;
	assign rf_tick = rf_level & ~rf_level_d;

	////////////////////////////////////////////////////////////////////////////////
	// Storage register, transparent while the strobe is high.

	// The host drives data and a high strobe; only the level is watched here.
	// load by strobe pulse.
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			prog <= `PROG_RESET;
		else if (strobe)
			prog <= bus;
	end

	////////////////////////////////////////////////////////////////////////////////
	// RF divider chain; held in reset by the strobe.

	rf_divider_chain u_rf_chain
	(
		.clk_i           (ref_clk_i),
		.rst_n_i         (rst_n),
		.hold_i          (strobe),
		.rf_tick_i       (rf_tick),
		.main_count_i    (prog.main_count),
		.swallow_count_i (prog.swallow_count),
		.div_pulse_o     (rf_pulse),
		.div_edge_o      (rf_edge)
	);

	// Reference divider by the pin ratio; a ratio of zero or one passes every cycle.
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_cnt <= `REF_RATIO_W'h0;
			ref_edge <= 1'b0;
		end
		else if (strobe)
		begin
			ref_cnt <= `REF_RATIO_W'h0;
			ref_edge <= 1'b0;
		end
		else if (ref_ratio <= `REF_RATIO_W'h1 || ref_cnt == ref_ratio - `REF_RATIO_W'h1)
		begin
			ref_cnt <= `REF_RATIO_W'h0;
			ref_edge <= 1'b1;
		end
		else
		begin
			ref_cnt <= ref_cnt + `REF_RATIO_W'h1;
			ref_edge <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Phase/frequency comparator and pump drive.

	assign pfd_ref_edge = dir ? ref_edge : rf_edge;
	assign pfd_rf_edge = dir ? rf_edge : ref_edge;

	// Edges that meet in one cycle cancel, so no correction is issued for them.
	// compare divided signals.
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
			pfd_state <= synth_core_pkg::PFD_IDLE;
		else if (strobe)
			pfd_state <= synth_core_pkg::PFD_IDLE;
		else
		begin
			unique case (pfd_state)
				synth_core_pkg::PFD_IDLE:
					if (pfd_ref_edge && !pfd_rf_edge)
						pfd_state <= synth_core_pkg::PFD_UP;
					else if (pfd_rf_edge && !pfd_ref_edge)
						pfd_state <= synth_core_pkg::PFD_DOWN;
				synth_core_pkg::PFD_UP:
					if (pfd_rf_edge)
						pfd_state <= synth_core_pkg::PFD_IDLE;
				synth_core_pkg::PFD_DOWN:
					if (pfd_ref_edge)
						pfd_state <= synth_core_pkg::PFD_IDLE;
			endcase
		end
	end

	// Pump outputs lag the comparator state by one cycle so that they come from flops.
	// pump off while strobe.
	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pump_up_o <= 1'b0;
			pump_down_o <= 1'b0;
			pump_output_en_o <= 1'b0;
		end
		else
		begin
			pump_up_o <= !strobe && pfd_state == synth_core_pkg::PFD_UP;
			pump_down_o <= !strobe && pfd_state == synth_core_pkg::PFD_DOWN;
			pump_output_en_o <= !strobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Gain, monitors and ratio status.

	assign ratio = {prog.main_count, `SWALLOW_W'h0} + {{(`RATIO_W-`SWALLOW_W){1'b0}}, prog.swallow_count};

	always_ff @(posedge ref_clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pump_gain_select_o <= `GAIN_X1_0;
			pump_gain_tenths_o <= `TENTHS_X1_0;
			divided_rf_pulse_o <= 1'b0;
			divided_ref_pulse_o <= 1'b0;
			ratio_steppable_o <= 1'b0;
		end
		else
		begin
			pump_gain_select_o <= prog.pump_gain_select;
			pump_gain_tenths_o <= gain_tenths(prog.pump_gain_select);
			divided_rf_pulse_o <= mon_en && (dir ? rf_pulse : ref_edge);
			divided_ref_pulse_o <= mon_en && (dir ? ref_edge : rf_pulse);
			ratio_steppable_o <= ratio >= `RATIO_W'(`MIN_STEP_RATIO) &&
				prog.swallow_count < prog.main_count;
		end
	end

endmodule // synth_core

// ---- hw/synth_core_defs.svh ----
// Constants for the synthesiser digital core: bus layout, prescaler moduli, gain codes.
// Assumes it is included by its bare name wherever a constant is needed.
`ifndef SYNTH_CORE_DEFS_SVH
`define SYNTH_CORE_DEFS_SVH

// Programming bus and field widths.
`define BUS_W            16
`define SWALLOW_W        3
`define MAIN_W           11
`define GAIN_W           2
`define REF_RATIO_W      10

// Dual-modulus prescaler: low modulus and high modulus, RF cycles per prescaler cycle.
`define PRESC_LOW        4'h8
`define PRESC_HIGH       4'h9
`define PRESC_CNT_W      4

// Smallest ratio from which every integer ratio can be stepped, low modulus times one less.
`define MIN_STEP_RATIO   (8 * (8 - 1))
`define RATIO_W          14

// Monitor pulse length in RF cycles, one low-modulus prescaler cycle.
`define RF_PULSE_LEN     4'h8

// Pump gain select codes and their factors in tenths.
`define GAIN_X1_0        2'h0
`define GAIN_X1_5        2'h1
`define GAIN_X2_5        2'h2
`define GAIN_X4_0        2'h3
`define GAIN_TENTHS_W    6
`define TENTHS_X1_0      6'h0A
`define TENTHS_X1_5      6'h0F
`define TENTHS_X2_5      6'h19
`define TENTHS_X4_0      6'h28

// Reset value of the storage register.
`define PROG_RESET       16'h0000

`endif

// ---- hw/synth_core_pkg.sv ----
// Types shared by the synthesiser core and its self-checking bench.
// Assumes synth_core_defs.svh is on the include path.
`include "synth_core_defs.svh"

package synth_core_pkg;

	// Word held in the storage register, bit 15 first.
	typedef struct packed {
		logic [`GAIN_W-1:0]    pump_gain_select;
		logic [`MAIN_W-1:0]    main_count;
		logic [`SWALLOW_W-1:0] swallow_count;
	} prog_word_s;

	// Phase/frequency comparator states.
	typedef enum logic [2:0] {
		PFD_IDLE = 3'b001,
		PFD_UP   = 3'b010,
		PFD_DOWN = 3'b100
	} pfd_state_e;

endpackage

// ---- hw/rf_divider_chain.sv ----
// Dual-modulus prescaler with swallow and main counters, stepped by RF edge enables.
// Assumes rf_tick_i is a one-cycle enable per RF cycle and hold_i is already synchronous.
`timescale 1ns/1ns
`include "synth_core_defs.svh"

module rf_divider_chain
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  hold_i,
	input  wire logic                  rf_tick_i,
	input  wire logic [`MAIN_W-1:0]    main_count_i,
	input  wire logic [`SWALLOW_W-1:0] swallow_count_i,
	output logic                       div_pulse_o,
	output logic                       div_edge_o
);

	logic [`PRESC_CNT_W-1:0] psc;
	logic [`MAIN_W-1:0]      main_idx;
	logic [`SWALLOW_W-1:0]   swallow_left;
	logic [`PRESC_CNT_W-1:0] next_psc;
	logic [`MAIN_W-1:0]      next_main_idx;
	logic [`SWALLOW_W-1:0]   next_swallow_left;
	logic                    next_wrap;
	logic [`PRESC_CNT_W-1:0] modulus;
	logic                    main_last;

	////////////////////////////////////////////////////////////////////////////////
	// Next-state arithmetic of the counter chain.

	always_comb
	begin
		modulus = (swallow_left != `SWALLOW_W'h0) ? `PRESC_HIGH : `PRESC_LOW;
		// A main count of zero always counts as last, so it wraps on every prescaler cycle.
		main_last = (main_count_i == `MAIN_W'h0) ||
			(main_idx == main_count_i - `MAIN_W'h1);
		next_psc = psc;
		next_main_idx = main_idx;
		next_swallow_left = swallow_left;
		next_wrap = 1'b0;
		if (rf_tick_i)
		begin
			if (psc == modulus - `PRESC_CNT_W'h1)
			begin
				next_psc = `PRESC_CNT_W'h0;
				// ratio main times eight plus swallow.
				if (main_last)
				begin
					next_main_idx = `MAIN_W'h0;
					next_swallow_left = swallow_count_i;
					next_wrap = 1'b1;
				end
				else
				begin
					next_main_idx = main_idx + `MAIN_W'h1;
					if (swallow_left != `SWALLOW_W'h0)
						next_swallow_left = swallow_left - `SWALLOW_W'h1;
				end
			end
			else
				next_psc = psc + `PRESC_CNT_W'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter state; the strobe clears the counters and preloads the swallow count.

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			psc <= `PRESC_CNT_W'h0;
			main_idx <= `MAIN_W'h0;
			swallow_left <= `SWALLOW_W'h0;
		end
		else if (hold_i)
		begin
			psc <= `PRESC_CNT_W'h0;
			main_idx <= `MAIN_W'h0;
			swallow_left <= swallow_count_i;
		end
		else
		begin
			psc <= next_psc;
			main_idx <= next_main_idx;
			swallow_left <= next_swallow_left;
		end
	end

	// Output pulse covers the first eight RF cycles of each main cycle.
	// The pulse is cut at eight even when that prescaler cycle runs at nine.
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			div_pulse_o <= 1'b0;
			div_edge_o <= 1'b0;
		end
		else if (hold_i)
		begin
			div_pulse_o <= 1'b0;
			div_edge_o <= 1'b0;
		end
		else
		begin
			if (next_wrap)
				div_pulse_o <= 1'b1;
			else if (rf_tick_i && next_main_idx == `MAIN_W'h0 && next_psc >= `RF_PULSE_LEN)
				div_pulse_o <= 1'b0;
			else if (next_main_idx != `MAIN_W'h0)
				div_pulse_o <= 1'b0;
			div_edge_o <= next_wrap;
		end
	end

endmodule // rf_divider_chain

// ---- test/synth_core_asserts.sv ----
// Pin-level checks for the synthesiser core.
// Assumes it is bound to synth_core and sees only its ports.
`timescale 1ns/1ns
`include "synth_core_defs.svh"

module synth_core_asserts
(
	input wire logic                      ref_clk_i,
	input wire logic                      resetn_i,
	input wire logic                      strobe_i,
	input wire logic [`BUS_W-1:0]         prog_bus_i,
	input wire logic                      monitor_en_i,
	input wire logic                      pump_up_o,
	input wire logic                      pump_down_o,
	input wire logic                      pump_output_en_o,
	input wire logic [`GAIN_W-1:0]        pump_gain_select_o,
	input wire logic [`GAIN_TENTHS_W-1:0] pump_gain_tenths_o,
	input wire logic                      divided_rf_pulse_o,
	input wire logic                      divided_ref_pulse_o
);
	// One clock domain, so the clock and the reset are given once.
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	////////////////////////////////////////
	a_pump_excl: assert property (!(pump_up_o && pump_down_o))
		else $error("up and down high together");
	a_pump_gate: assert property (!pump_output_en_o |-> !pump_up_o && !pump_down_o)
		else $error("pump active while disabled");
	// Eight cycles leave room for the pin filter, which takes about five.
	a_strobe_off: assert property (strobe_i [*8] |-> !pump_output_en_o)
		else $error("pump enabled during strobe");
	a_strobe_on: assert property (!strobe_i [*8] |-> pump_output_en_o)
		else $error("pump not enabled after strobe");
	a_gain_hold: assert property (!strobe_i [*8] |->
		$stable(pump_gain_select_o) && $stable(pump_gain_tenths_o))
		else $error("gain moved with strobe low");
	a_gain_load: assert property ((strobe_i && $stable(prog_bus_i)) [*8] |->
		pump_gain_select_o == prog_bus_i[15:14])
		else $error("gain does not follow bus");
	a_gain_map: assert property (pump_gain_tenths_o ==
		(pump_gain_select_o == `GAIN_X1_0 ? `TENTHS_X1_0 :
		pump_gain_select_o == `GAIN_X1_5 ? `TENTHS_X1_5 :
		pump_gain_select_o == `GAIN_X2_5 ? `TENTHS_X2_5 : `TENTHS_X4_0))
		else $error("gain factor wrong");
	a_mon_off: assert property (!monitor_en_i [*8] |->
		!divided_rf_pulse_o && !divided_ref_pulse_o)
		else $error("monitor active while disabled");
endmodule // synth_core_asserts

bind synth_core synth_core_asserts chk
(
	.ref_clk_i          (ref_clk_i),
	.resetn_i           (resetn_i),
	.strobe_i           (strobe_i),
	.prog_bus_i         (prog_bus_i),
	.monitor_en_i       (monitor_en_i),
	.pump_up_o          (pump_up_o),
	.pump_down_o        (pump_down_o),
	.pump_output_en_o   (pump_output_en_o),
	.pump_gain_select_o (pump_gain_select_o),
	.pump_gain_tenths_o (pump_gain_tenths_o),
	.divided_rf_pulse_o (divided_rf_pulse_o),
	.divided_ref_pulse_o(divided_ref_pulse_o)
);

// ---- test/host_model.sv ----
// Host that loads the core through the parallel bus and the strobe.
// Assumes its clock is the core's clock; drives 1 ns after each edge.
`timescale 1ns/1ns
`include "synth_core_defs.svh"

module host_model
(
	input  wire logic         clk_i,
	output logic              strobe_o,
	output logic [`BUS_W-1:0] bus_o
);
	// Idle host: strobe low.
	initial
	begin
		strobe_o = 1'b0;
		bus_o = `PROG_RESET;
	end

	////////////////////////////////////////
	// bus then strobe pulse
	// strobe kept short
	// The pulse is eleven cycles: long enough for the pin filter, short for the loop.
	// The final word stands for the last nine cycles, so the gain check sees it settle.
	task load2(input logic [`BUS_W-1:0] first, input logic [`BUS_W-1:0] last);
		@(posedge clk_i);
		#1;
		bus_o = first;
		strobe_o = 1'b1;
		repeat (2) @(posedge clk_i);
		#1;
		bus_o = last;
		repeat (9) @(posedge clk_i);
		#1;
		strobe_o = 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		bus_o = ~last; // A released bus shows no stale value.
	endtask
endmodule // host_model

// ---- test/synth_divider_strobe_load_tb_top.sv ----
// Self-checking bench for the synthesiser core.
// Assumes host_model and the bound checker are compiled with it.
`timescale 1ns/1ns
`include "synth_core_defs.svh"

module synth_divider_strobe_load_tb_top;
	logic                      clk = 1'b0;
	logic                      resetn = 1'b0;
	logic                      strobe;
	logic [`BUS_W-1:0]         prog_bus;
	logic [`REF_RATIO_W-1:0]   ref_ratio = 10'h064;
	logic [1:0]                rf_cnt = 2'h0;
	logic                      rf_run = 1'b0;
	logic                      dir = 1'b1;
	logic                      mon_en = 1'b1;
	logic                      pump_up;
	logic                      pump_down;
	logic                      pump_en;
	logic [`GAIN_W-1:0]        gain_sel;
	logic [`GAIN_TENTHS_W-1:0] gain_tenths;
	logic                      rf_mon;
	logic                      ref_mon;
	logic                      steppable;
	int                        miscompares = 0;
	int                        compares = 0;
	int                        per;
	int                        wid;
	int                        up;
	int                        dn;
	logic [15:0]               hit;
	logic [5:0]                tt [4] = '{`TENTHS_X1_0, `TENTHS_X1_5, `TENTHS_X2_5, `TENTHS_X4_0};

	always #10 clk = ~clk;

	// RF input toggles every two clocks, the fastest legal rate.
	always @(posedge clk)
	begin
		#1;
		if (rf_run)
			rf_cnt <= rf_cnt + 2'h1;
	end

	synth_core uut
	(
		.ref_clk_i          (clk),
		.resetn_i           (resetn),
		.strobe_i           (strobe),
		.prog_bus_i         (prog_bus),
		.ref_ratio_i        (ref_ratio),
		.rf_in_i            (rf_cnt[1]),
		.control_dir_i      (dir),
		.monitor_en_i       (mon_en),
		.pump_up_o          (pump_up),
		.pump_down_o        (pump_down),
		.pump_output_en_o   (pump_en),
		.pump_gain_select_o (gain_sel),
		.pump_gain_tenths_o (gain_tenths),
		.divided_rf_pulse_o (rf_mon),
		.divided_ref_pulse_o(ref_mon),
		.ratio_steppable_o  (steppable)
	);

	host_model host
	(
		.clk_i   (clk),
		.strobe_o(strobe),
		.bus_o   (prog_bus)
	);

	////////////////////////////////////////
	// Verdict and stop; also used when a wait runs out.
	task end_of_test();
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] word(input int g, input int m, input int a);
		synth_core_pkg::prog_word_s w;
		w = '{g[1:0], m[10:0], a[2:0]};
		return w;
	endfunction

	function automatic logic pv(input bit s);
		return s ? ref_mon : rf_mon;
	endfunction

	// Bounded wait until the chosen monitor pin shows v, counting clocks.
	task wval(input bit s, input logic v, output int n);
		n = 0;
		while (pv(s) !== v && n < 3000)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000)
		begin
			miscompares++;
			end_of_test();
		end
	endtask

	task measure(input bit s);
		int n;
		wval(s, 1'b0, n);
		wval(s, 1'b1, n);
		wval(s, 1'b0, wid);
		wval(s, 1'b1, n);
		per = wid + n;
	endtask

	task settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	////////////////////////////////////////
	initial
	begin
		settle(2);
		resetn = 1'b1;
		settle(6);
		chk(gain_tenths, `TENTHS_X1_0);
		chk(pump_en, 1'b1);
		for (int g = 0; g < 4; g++)
		begin
			host.load2(word(g, 7, 3), word(g, 7, 3));
			settle(8);
			chk(gain_sel, g);
			chk(gain_tenths, tt[g]);
		end
		host.load2(word(1, 7, 0), word(2, 7, 0));
		settle(8);
		chk(gain_sel, 2'h2);
		chk(steppable, 1'b1);
		settle(12);
		chk(gain_sel, 2'h2);
		host.load2(word(0, 6, 7), word(0, 6, 7));
		settle(8);
		chk(steppable, 1'b0);
		rf_run = 1'b1;
		for (int a = 3; a < 8; a += 3)
		begin
			host.load2(word(0, 7, a), word(0, 7, a));
			measure(0);
			chk(per, (8 * 7 + a) * 4);
			chk(wid, 32);
		end
		dir = 1'b0;
		settle(8);
		measure(1);
		chk(per, 248);
		measure(0);
		chk(per, 100);
		ref_ratio = 10'h3E8;
		for (int d = 1; d >= 0; d--)
		begin
			dir = d[0];
			settle(20);
			up = 0;
			dn = 0;
			repeat (2000)
			begin
				settle(1);
				up += pump_up;
				dn += pump_down;
			end
			chk(dn > up, d);
		end
		mon_en = 1'b0;
		settle(10);
		hit = 0;
		repeat (600)
		begin
			settle(1);
			hit = hit | rf_mon | ref_mon;
		end
		chk(hit, 0);
		end_of_test();
	end
endmodule // synth_divider_strobe_load_tb_top
